// ==== boundary_scan_tap.v ====
// tap controller, instruction register and data paths of the test port
`timescale 1ns/10ps
`include "tap_defines.vh"
module boundary_scan_tap #(
  parameter NRX = `N_RX,
  parameter NTX = `N_TXC,
  parameter NSYS = `N_SYS,
  parameter NBIDI = `N_BIDI
) (
  input wire clk_sys,
  input wire rst,
  input wire tck,
  input wire tms,
  input wire tdi,
  input wire trstN,
  output reg tdoOut_ff,
  output reg tdoOeN_ff,
  input wire [NRX-1:0] lane_receive_input,
  input wire [NSYS-1:0] sysPinIn,
  input wire [NTX-1:0] coreTxEn,
  output reg [NTX-1:0] lane_transmit_output_en_ff,
  input wire [NBIDI-1:0] coreBidiOut,
  input wire [NBIDI-1:0] coreBidiOeN,
  input wire [NBIDI-1:0] padBidiIn,
  output reg [NBIDI-1:0] padBidiOut_ff,
  output reg [NBIDI-1:0] padBidiOeN_ff,
  output reg scanMode_ff
);
  localparam NB = NRX + NSYS + NTX + 2 * NBIDI;
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  reg [3:0] meta_ff;
  reg [3:0] sync_ff;
  reg tckLast_ff;
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      meta_ff <= 4'h8;
      sync_ff <= 4'h8;
      tckLast_ff <= 1'b0;
    end else begin
      meta_ff <= {trstN, tck, tms, tdi};
      sync_ff <= meta_ff;
      tckLast_ff <= sync_ff[2];
    end
  end
  wire tmsS = sync_ff[1];
  wire tdiS = sync_ff[0];
  wire tckRise = sync_ff[2] & ~tckLast_ff;
  wire tckFall = ~sync_ff[2] & tckLast_ff;
  // synchronised trst acts as an async clear; raw pin would glitch clk domain
  wire tapRst = rst | ~sync_ff[3];
  // ----------------------------------------
  // observed pin synchronisers
  // ----------------------------------------
  // observed pins are asynchronous to clk_sys; two flops before any capture
  localparam NOBS = NRX + NSYS + NBIDI;
  reg [NOBS-1:0] obsMeta_ff;
  reg [NOBS-1:0] obsSync_ff;
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      obsMeta_ff <= {NOBS{1'b0}};
      obsSync_ff <= {NOBS{1'b0}};
    end else begin
      obsMeta_ff <= {padBidiIn, sysPinIn, lane_receive_input};
      obsSync_ff <= obsMeta_ff;
    end
  end
  wire [NRX-1:0] rxS = obsSync_ff[NRX-1:0];
  wire [NSYS-1:0] sysS = obsSync_ff[NRX+NSYS-1:NRX];
  wire [NBIDI-1:0] padS = obsSync_ff[NOBS-1:NRX+NSYS];
  // ----------------------------------------
  // tap state machine
  // ----------------------------------------
  reg [3:0] state_ff;
  reg [3:0] nxt_state;
  always @* begin
    case (state_ff)
      `ST_RESET: nxt_state = tmsS ? `ST_RESET : `ST_IDLE;
      `ST_IDLE: nxt_state = tmsS ? `ST_SEL_DR : `ST_IDLE;
      `ST_SEL_DR: nxt_state = tmsS ? `ST_SEL_IR : `ST_CAP_DR;
      `ST_CAP_DR: nxt_state = tmsS ? `ST_EX1_DR : `ST_SH_DR;
      `ST_SH_DR: nxt_state = tmsS ? `ST_EX1_DR : `ST_SH_DR;
      `ST_EX1_DR: nxt_state = tmsS ? `ST_UPD_DR : `ST_PAU_DR;
      `ST_PAU_DR: nxt_state = tmsS ? `ST_EX2_DR : `ST_PAU_DR;
      `ST_EX2_DR: nxt_state = tmsS ? `ST_UPD_DR : `ST_SH_DR;
      `ST_UPD_DR: nxt_state = tmsS ? `ST_SEL_DR : `ST_IDLE;
      `ST_SEL_IR: nxt_state = tmsS ? `ST_RESET : `ST_CAP_IR;
      `ST_CAP_IR: nxt_state = tmsS ? `ST_EX1_IR : `ST_SH_IR;
      `ST_SH_IR: nxt_state = tmsS ? `ST_EX1_IR : `ST_SH_IR;
      `ST_EX1_IR: nxt_state = tmsS ? `ST_UPD_IR : `ST_PAU_IR;
      `ST_PAU_IR: nxt_state = tmsS ? `ST_EX2_IR : `ST_PAU_IR;
      `ST_EX2_IR: nxt_state = tmsS ? `ST_UPD_IR : `ST_SH_IR;
      `ST_UPD_IR: nxt_state = tmsS ? `ST_SEL_DR : `ST_IDLE;
      default: nxt_state = `ST_RESET;
    endcase
  end
  always @(posedge clk_sys or posedge tapRst) begin
    if (tapRst) begin
      state_ff <= `ST_RESET;
    end else if (tckRise) begin
      state_ff <= nxt_state;
    end
  end
  // ----------------------------------------
  // instruction register
  // ----------------------------------------
  reg [`IR_W-1:0] irShift_ff;
  reg [`IR_W-1:0] ir_ff;
  always @(posedge clk_sys or posedge tapRst) begin
    if (tapRst) begin
      irShift_ff <= `OP_CAPTURE;
      ir_ff <= `OP_IDCODE;
    end else if (tckRise) begin
      if (state_ff == `ST_CAP_IR) begin
        irShift_ff <= `OP_CAPTURE;
      end else if (state_ff == `ST_SH_IR) begin
        irShift_ff <= {tdiS, irShift_ff[`IR_W-1:1]};
      end
    end else if (tckFall && state_ff == `ST_UPD_IR) begin
      ir_ff <= irShift_ff;
    end else if (tckFall && state_ff == `ST_RESET) begin
      ir_ff <= `OP_IDCODE;
    end
  end
  // ----------------------------------------
  // instruction decode
  // ----------------------------------------
  wire selBscan = (ir_ff == `OP_EXTEST) | (ir_ff == `OP_SAMPLE);
  wire selId = (ir_ff == `OP_IDCODE);
  wire selBypass = ~selBscan & ~selId;
  wire drivePins = (ir_ff == `OP_EXTEST) | (ir_ff == `OP_CLAMP);
  wire floatPins = (ir_ff == `OP_HIGHZ);
  wire capDr = tckRise & (state_ff == `ST_CAP_DR);
  wire shDr = tckRise & (state_ff == `ST_SH_DR);
  // ----------------------------------------
  // bypass and identification
  // ----------------------------------------
  reg bypass_ff;
  reg [`ID_W-1:0] idShift_ff;
  always @(posedge clk_sys or posedge tapRst) begin
    if (tapRst) begin
      bypass_ff <= 1'b0;
      idShift_ff <= `ID_VALUE;
    end else begin
      if (capDr) begin
        bypass_ff <= 1'b0;
      end else if (shDr) begin
        bypass_ff <= tdiS;
      end
      if (capDr) begin
        idShift_ff <= `ID_VALUE;
      end else if (shDr) begin
        idShift_ff <= {tdiS, idShift_ff[`ID_W-1:1]};
      end
    end
  end
  // ----------------------------------------
  // boundary chain
  // ----------------------------------------
  // order from tdi: bidi data, bidi enable, tx control, system, receive
  // refclk, mode straps, test pins and resistors carry no cell; only the test pins have ports
  wire [NB-1:0] par;
  wire [NB-1:0] sh;
  wire [NB-1:0] upd;
  wire [NB:0] chain;
  assign chain[NB] = tdiS;
  assign par[NRX-1:0] = rxS;
  assign par[NRX+NSYS-1:NRX] = sysS;
  assign par[NRX+NSYS+NTX-1:NRX+NSYS] = coreTxEn;
  assign par[NRX+NSYS+NTX+NBIDI-1:NRX+NSYS+NTX] = ~coreBidiOeN;
  genvar g;
  generate
    for (g = 0; g < NBIDI; g = g + 1) begin : gBidi
      // capture core data when driven and not under test, else pad
      assign par[NB-NBIDI+g] = (~coreBidiOeN[g] && ir_ff != `OP_EXTEST) ?
        coreBidiOut[g] : padS[g];
    end
    for (g = 0; g < NB; g = g + 1) begin : gCell
      bscan_cell uCell (
        .clk_sys(clk_sys),
        .rst(tapRst),
        .capEn(capDr & selBscan),
        .shiftEn(shDr & selBscan),
        .updateEn(tckFall & (state_ff == `ST_UPD_DR) & selBscan),
        .parallelIn(par[g]),
        .serialIn(chain[g+1]),
        .shift_ff(sh[g]),
        .update_ff(upd[g])
      );
      assign chain[g] = sh[g];
    end
  endgenerate
  // ----------------------------------------
  // pin outputs and tdo
  // ----------------------------------------
  wire [NTX-1:0] updTx = upd[NRX+NSYS+NTX-1:NRX+NSYS];
  wire [NBIDI-1:0] updOe = upd[NRX+NSYS+NTX+NBIDI-1:NRX+NSYS+NTX];
  wire [NBIDI-1:0] updDat = upd[NB-1:NB-NBIDI];
  wire tdoSel = (state_ff == `ST_SH_IR) ? irShift_ff[0] :
    selBscan ? chain[0] : selId ? idShift_ff[0] : bypass_ff;
  wire shifting = (state_ff == `ST_SH_IR) | (state_ff == `ST_SH_DR);
  always @(posedge clk_sys or posedge tapRst) begin
    if (tapRst) begin
      tdoOut_ff <= 1'b0;
      tdoOeN_ff <= 1'b1;
      lane_transmit_output_en_ff <= {NTX{1'b0}};
      padBidiOut_ff <= {NBIDI{1'b0}};
      padBidiOeN_ff <= {NBIDI{1'b1}};
      scanMode_ff <= 1'b0;
    end else begin
      if (tckFall) begin
        tdoOut_ff <= tdoSel;
        tdoOeN_ff <= ~shifting;
      end
      scanMode_ff <= drivePins | floatPins;
      // each tx pair gated by its one shared control cell
      lane_transmit_output_en_ff <= floatPins ? {NTX{1'b0}} :
        drivePins ? updTx : coreTxEn;
      padBidiOut_ff <= drivePins ? updDat : coreBidiOut;
      padBidiOeN_ff <= floatPins ? {NBIDI{1'b1}} :
        drivePins ? ~updOe : coreBidiOeN;
    end
  end
endmodule

// ==== tap_defines.vh ====
// constants for the boundary-scan test access port
`ifndef TAP_DEFINES_VH
`define TAP_DEFINES_VH
// ----------------------------------------
// tap states
// ----------------------------------------
`define ST_RESET 4'hf
`define ST_IDLE 4'hc
`define ST_SEL_DR 4'h7
`define ST_CAP_DR 4'h6
`define ST_SH_DR 4'h2
`define ST_EX1_DR 4'h1
`define ST_PAU_DR 4'h3
`define ST_EX2_DR 4'h0
`define ST_UPD_DR 4'h5
`define ST_SEL_IR 4'h4
`define ST_CAP_IR 4'he
`define ST_SH_IR 4'ha
`define ST_EX1_IR 4'h9
`define ST_PAU_IR 4'hb
`define ST_EX2_IR 4'h8
`define ST_UPD_IR 4'hd
// ----------------------------------------
// instructions
// ----------------------------------------
`define IR_W 6
`define OP_EXTEST 6'h00
`define OP_SAMPLE 6'h01
`define OP_IDCODE 6'h02
`define OP_HIGHZ 6'h03
`define OP_CAPTURE 6'h2d
`define OP_CLAMP 6'h3e
`define ID_W 32
// arbitrary identification value
`define ID_VALUE 32'h00000001
// ----------------------------------------
// boundary chain layout
// ----------------------------------------
`define N_RX 12
`define N_TXC 6
`define N_SYS 3
`define N_BIDI 11
`endif

// ==== bscan_cell.v ====
// one boundary cell: capture/shift stage plus update latch
`timescale 1ns/10ps
module bscan_cell (
  input wire clk_sys,
  input wire rst,
  input wire capEn,
  input wire shiftEn,
  input wire updateEn,
  input wire parallelIn,
  input wire serialIn,
  output reg shift_ff,
  output reg update_ff
);
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      shift_ff <= 1'b0;
    end else if (capEn) begin
      shift_ff <= parallelIn;
    end else if (shiftEn) begin
      shift_ff <= serialIn;
    end
  end
  // update taken on the falling test clock edge
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      update_ff <= 1'b0;
    end else if (updateEn) begin
      update_ff <= shift_ff;
    end
  end
endmodule

// ==== scan_tester.sv ====
// behavioural boundary-scan test controller
`timescale 1ns/10ps
module scan_tester (
  input wire clk_sys,
  input wire tdoOut_ff,
  input wire tdoOeN_ff,
  output reg tck,
  output reg tms,
  output reg tdi,
  output reg trstN
);
  // ----
  // test clock frames
  // ----
  reg dummy;
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
    trstN = 1'b1;
  end
  // 8 system cycles a bit; tck idles low, so enter on a falling clk_sys edge
  task step(input t, input d, output o);
    begin
      tms = t;
      tdi = d;
      repeat (4) @(negedge clk_sys);
      tck = 1'b1;
      repeat (4) @(negedge clk_sys);
      // released line shows the inverse, so a float never passes for data
      o = tdoOeN_ff ? ~tdoOut_ff : tdoOut_ff;
      tck = 1'b0;
    end
  endtask
  task tmsReset;
    begin
      repeat (5) step(1'b1, 1'b1, dummy);
    end
  endtask
  task trstPulse;
    begin
      trstN = 1'b0;
      repeat (6) @(negedge clk_sys);
      trstN = 1'b1;
      repeat (4) @(negedge clk_sys);
    end
  endtask
endmodule

// ==== boundary_scan_tap_checker.sv ====
// assertions on the test port pins and the pad and tx enables
`timescale 1ns/10ps
module boundary_scan_tap_checker #(
  parameter NTX = 6,
  parameter NBIDI = 11
) (
  input wire clk_sys,
  input wire rst,
  input wire tck,
  input wire tms,
  input wire trstN,
  input wire tdoOut_ff,
  input wire tdoOeN_ff,
  input wire [NTX-1:0] coreTxEn,
  input wire [NTX-1:0] lane_transmit_output_en_ff,
  input wire [NBIDI-1:0] coreBidiOeN,
  input wire [NBIDI-1:0] padBidiOeN_ff,
  input wire scanMode_ff
);
  // ----
  // properties
  // ----
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  reg [2:0] hiCnt_ff;
  always @(posedge clk_sys or posedge rst) begin
    if (rst) hiCnt_ff <= 3'h0;
    else if ($rose(tck)) hiCnt_ff <= !tms ? 3'h0 : (hiCnt_ff == 3'h5 ? 3'h5 : hiCnt_ff + 3'h1);
  end
  reset_hiz_a: assert property (disable iff (1'b0) rst |-> tdoOeN_ff && (&padBidiOeN_ff))
    else $error("outputs not floating in reset");
  // test reset clears tdo at any time, so such changes are left out
  tdo_edge_a: assert property ($changed(tdoOut_ff) && $past(trstN, 2)
    |-> !$past(tck, 2) && !$past(tck, 3))
    else $error("tdo moved away from a tck fall");
  oe_edge_a: assert property ($changed(tdoOeN_ff) && $past(trstN, 2)
    |-> !$past(tck, 2) && !$past(tck, 3))
    else $error("tdo enable moved away from a tck fall");
  tms_reset_a: assert property ($rose(hiCnt_ff == 3'h5) |-> ##[1:8] (!scanMode_ff && tdoOeN_ff))
    else $error("five tms highs did not reset");
  trst_reset_a: assert property ((!trstN)[*4] |-> ##[0:4] (!scanMode_ff && tdoOeN_ff))
    else $error("test reset ignored");
  // synced test reset holds pads floating two to three cycles after the pin
  pad_pass_a: assert property (!$past(rst) && !scanMode_ff && !$past(scanMode_ff)
    && $past(trstN, 2) && $past(trstN, 3) |-> padBidiOeN_ff == $past(coreBidiOeN))
    else $error("pad enable not from core");
  tx_pass_a: assert property (!$past(rst) && !scanMode_ff && !$past(scanMode_ff)
    && $past(trstN, 2) && $past(trstN, 3) |-> lane_transmit_output_en_ff == $past(coreTxEn))
    else $error("tx enable not from core");
  mode_update_a: assert property ($rose(scanMode_ff) |-> !$past(tck, 2) && !$past(tck, 3))
    else $error("mode changed outside update");
  cover property ($fell(tdoOeN_ff));
  cover property ($rose(scanMode_ff));
  cover property ($rose(hiCnt_ff == 3'h5));
endmodule
bind boundary_scan_tap boundary_scan_tap_checker #(.NTX(NTX), .NBIDI(NBIDI)) chk (
  .clk_sys(clk_sys), .rst(rst), .tck(tck), .tms(tms), .trstN(trstN), .tdoOut_ff(tdoOut_ff),
  .tdoOeN_ff(tdoOeN_ff), .coreTxEn(coreTxEn),
  .lane_transmit_output_en_ff(lane_transmit_output_en_ff), .coreBidiOeN(coreBidiOeN),
  .padBidiOeN_ff(padBidiOeN_ff), .scanMode_ff(scanMode_ff));

// ==== boundary_scan_tap_tb_top.sv ====
// self-checking bench for the test port
`timescale 1ns/10ps
`include "tap_defines.vh"
module boundary_scan_tap_tb_top;
  // ----
  // set-up
  // ----
  // clock opens high so the reset edge lands before the first rise
  reg clk_sys = 1'b1;
  reg rst = 1'b0;
  wire tck, tms, tdi, trstN, tdoOut_ff, tdoOeN_ff, scanMode_ff;
  reg [11:0] rxIn = 12'ha5c;
  reg [2:0] sysIn = 3'h5;
  reg [5:0] txEn = 6'h2b;
  reg [10:0] bOut = 11'h3a6;
  reg [10:0] bOeN = 11'h0f0;
  reg [10:0] ext = 11'h555;
  wire [10:0] pOut, pOeN, padIn;
  wire [5:0] txOe;
  integer mismatches = 0, num_checks = 0, cycles = 0;
  reg [63:0] so;
  reg o1;
  reg [42:0] pat = 43'h5a3c96e1f0b;
  assign padIn = (pOut & ~pOeN) | (ext & pOeN);
  always #12.5 clk_sys = ~clk_sys;
  scan_tester tester (.clk_sys(clk_sys), .tdoOut_ff(tdoOut_ff), .tdoOeN_ff(tdoOeN_ff),
    .tck(tck), .tms(tms), .tdi(tdi), .trstN(trstN));
  boundary_scan_tap dut (.clk_sys(clk_sys), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi),
    .trstN(trstN), .tdoOut_ff(tdoOut_ff), .tdoOeN_ff(tdoOeN_ff), .lane_receive_input(rxIn),
    .sysPinIn(sysIn), .coreTxEn(txEn), .lane_transmit_output_en_ff(txOe), .coreBidiOut(bOut),
    .coreBidiOeN(bOeN), .padBidiIn(padIn), .padBidiOut_ff(pOut), .padBidiOeN_ff(pOeN),
    .scanMode_ff(scanMode_ff));
  task conclude;
    begin
      if (mismatches == 0 && num_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask
  always @(posedge clk_sys) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      mismatches = mismatches + 1;
      conclude;
    end
  end
  task check(input [63:0] seen, input [63:0] exp);
    begin
      num_checks = num_checks + 1;
      if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  // ----
  // scans, entered and left in run-test/idle
  // ----
  task scan(input ir, input integer n, input [63:0] din);
    integer i;
    begin
      so = 64'h0;
      tester.step(1'b1, 1'b0, o1);
      if (ir) tester.step(1'b1, 1'b0, o1);
      tester.step(1'b0, 1'b0, o1);
      tester.step(1'b0, 1'b0, o1);
      for (i = 0; i < n; i = i + 1) begin
        tester.step(i == n - 1, din[i], o1);
        so[i] = o1;
      end
      tester.step(1'b1, 1'b0, o1);
      tester.step(1'b0, 1'b0, o1);
    end
  endtask
  task loadIr(input [5:0] op);
    begin
      scan(1'b1, 6, {58'h0, op});
      check(so, 64'h2d);
    end
  endtask
  task readId;
    begin
      check(tdoOeN_ff, 1'b1);
      scan(1'b0, 32, 64'h0);
      check(so, `ID_VALUE);
    end
  endtask
  // preload through sample, then drive it; highz, clamp and a reserved code
  task cellModes;
    begin
      loadIr(`OP_SAMPLE);
      scan(1'b0, 43, {21'h0, pat});
      check(so, {21'h0, bOut & ~bOeN | ext & bOeN, ~bOeN, txEn, sysIn, rxIn});
      loadIr(`OP_EXTEST);
      check({scanMode_ff, txOe, pOeN, pOut}, {1'b1, pat[20:15], ~pat[31:21], pat[42:32]});
      loadIr(`OP_HIGHZ);
      check({scanMode_ff, txOe, pOeN}, {1'b1, 6'h0, 11'h7ff});
      scan(1'b0, 4, 64'h9);
      check(so, 64'h2);
      loadIr(`OP_CLAMP);
      check({scanMode_ff, txOe, pOeN, pOut}, {1'b1, pat[20:15], ~pat[31:21], pat[42:32]});
      scan(1'b0, 4, 64'h6);
      check(so, 64'hc);
      loadIr(6'h10);
      check({scanMode_ff, txOe, pOeN}, {1'b0, txEn, bOeN});
      scan(1'b0, 3, 64'h5);
      check(so, 64'h2);
    end
  endtask
  task resets;
    begin
      loadIr(`OP_HIGHZ);
      tester.tmsReset;
      check({scanMode_ff, tdoOeN_ff}, 2'h1);
      tester.step(1'b0, 1'b0, o1);
      readId;
      loadIr(`OP_CLAMP);
      bOeN = 11'h00f;
      tester.trstPulse;
      check({scanMode_ff, pOeN}, {1'b0, bOeN});
      tester.step(1'b0, 1'b0, o1);
      readId;
    end
  endtask
  initial begin
    @(negedge clk_sys);
    rst = 1'b1;
    repeat (12) @(negedge clk_sys);
    rst = 1'b0;
    repeat (4) @(negedge clk_sys);
    tester.step(1'b0, 1'b0, o1);
    readId;
    cellModes;
    resets;
    conclude;
  end
endmodule
